// file: rtl/tick_timer_defs.vh
// constants for the seconds clock timer: register addresses, bit positions, reset values
// assumes inclusion by bare name from the design files
`ifndef TICK_TIMER_DEFS_VH
`define TICK_TIMER_DEFS_VH
// register addresses (24-bit i/o space)
`define ADDR_W 24
`define A_PRIO 24'h00FF21
`define A_ENAB 24'h00FF25
`define A_FLAG 24'h00FF29
`define A_CTRL 24'h00FF50
`define A_DIV 24'h00FF51
`define A_SEC 24'h00FF52
// control bits
`define B_RUN 0
`define B_CLR 1
// priority field position in the shared priority register
`define B_PRIO_LO 2
`define B_PRIO_HI 3
// event bits in enable and flag registers: 32hz, 8hz, 2hz, 1hz, minute
`define B_EV_LO 3
`define B_EV_HI 7
`define N_EV 5
// divider taps for 32, 8, 2, 1 hz
`define TAP_32 2
`define TAP_8 4
`define TAP_2 6
`define TAP_1 7
// reset values
`define RST_BYTE 8'h00
`define RST_SEC 7'h00
`define RST_LVL 2'h0
`define RST_EV 5'h00
// bcd limits
`define UNITS_MAX 4'h9
`define TENS_MAX 3'h5
// tick timing
`define CLK_HZ 50000000
`define TICK_HZ 256
`endif

// file: rtl/tick_gen.v
// 256 hz tick generator derived from the low-speed oscillator reference
// assumes ref_clk at the rate in the defs header; ce freezes the count
`timescale 1ns/1ps
`include "tick_timer_defs.vh"
module tick_gen #(
    parameter integer CYCLES = `CLK_HZ / `TICK_HZ
) (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    output reg tick
);
    // cycle counter, wide enough for the default divide
    reg [17:0] cnt_reg;
    ////////////////////////////////////////////////////////////////////////
    // count down and pulse once per period
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 18'h00000;
            tick <= 1'b0;
        end else if (ce) begin
            if (cnt_reg == 18'h00000) begin
                cnt_reg <= CYCLES[17:0] - 18'h00001;
                tick <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg - 18'h00001;
                tick <= 1'b0;
            end
        end
    end
endmodule

// file: rtl/bcd_seconds.v
// 7-bit bcd seconds counter, 0 to 59, with preset and clear
// assumes inc, load and clr are one-cycle pulses from the main timer
`timescale 1ns/1ps
`include "tick_timer_defs.vh"
module bcd_seconds (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire inc,
    input wire load,
    input wire [6:0] load_val,
    input wire clr,
    output reg [6:0] value,
    output wire wrap
);
    // units and tens digits
    wire [3:0] units = value[3:0];
    wire [2:0] tens = value[6:4];
    // overflow past 59
    assign wrap = inc && units == `UNITS_MAX && tens == `TENS_MAX;
    ////////////////////////////////////////////////////////////////////////
    // counter update: clear, then preset, then count
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            value <= `RST_SEC;
        end else if (ce) begin
            if (clr) begin
                value <= `RST_SEC;
            end else if (load) begin
                value <= load_val;
            end else if (inc) begin
                if (units != `UNITS_MAX) begin
                    value <= {tens, units + 4'h1};
                end else if (tens != `TENS_MAX) begin
                    value <= {tens + 3'h1, 4'h0};
                end else begin
                    value <= `RST_SEC;
                end
            end
        end
    end
endmodule

// file: rtl/seconds_clock_timer.v
// seconds clock timer: 8-bit divider, bcd seconds counter, event flags, irq level
// assumes a cpu-side register port with one-cycle strobes and read data one cycle later
// Function
// - divider register read-only, bit0 128hz tap
// - divider writes are ignored
// - divider clears at reset
// - seconds: bcd tens bits6-4, units 3-0
// - seconds write loads the counter
// - seconds write also clears divider
// - overflow wraps to zero, not preset
// - seconds counter clears at reset
// - clear bit one clears both counters
// - running timer resumes at once after clear
// - stopped timer holds zero after clear
// - clear bit write-only, reads zero
// - five enable bits 7-3, reset zero
// - five flags bits 7-3, reset zero
// - run bit starts, stop keeps count
// - divider steps at 256hz, feeds seconds
// - flags set on tap falls, minute overflow
// - two-bit priority gives interrupt level
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "tick_timer_defs.vh"
module seconds_clock_timer #(
    parameter integer TICK_CYCLES = `CLK_HZ / `TICK_HZ
) (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire [23:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    output wire [1:0] irq_level,
    output wire irq_req
);
    ////////////////////////////////////////////////////////////////////////
    // state
    reg [7:0] divider_value_reg; // binary divider
    reg run_stop_reg; // run/stop
    reg [1:0] tick_irq_level_reg; // priority field
    reg [`N_EV-1:0] en_reg; // enables, bit0 = 32hz .. bit4 = minute
    reg [`N_EV-1:0] flag_reg; // flags, same order
    reg [`N_EV-1:0] flag_next;
    reg [7:0] div_prev_reg; // previous divider for tap-fall detect
    wire tick; // 256 hz pulse
    wire [6:0] seconds_value;
    wire sec_wrap;
    ////////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_prio = wr && addr == `A_PRIO;
    wire wr_enab = wr && addr == `A_ENAB;
    wire wr_flag = wr && addr == `A_FLAG;
    wire wr_ctrl = wr && addr == `A_CTRL;
    wire wr_sec = wr && addr == `A_SEC;
    // clear strobe from the write-only bit
    wire timer_clear = wr_ctrl && wdata[`B_CLR];
    // divider advances only while running
    wire step = tick && run_stop_reg;
    // divider overflow feeds the seconds counter
    wire div_carry = step && divider_value_reg == 8'hFF;
    ////////////////////////////////////////////////////////////////////////
    // tick source
    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick)
    );
    ////////////////////////////////////////////////////////////////////////
    // seconds counter
    bcd_seconds u_sec (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .inc(div_carry),
        .load(wr_sec),
        .load_val(wdata[6:0]),
        .clr(timer_clear),
        .value(seconds_value),
        .wrap(sec_wrap)
    );
    ////////////////////////////////////////////////////////////////////////
    // divider: clear or preset clears, else counts on step
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divider_value_reg <= `RST_BYTE;
        end else if (ce) begin
            if (timer_clear) begin
                divider_value_reg <= `RST_BYTE;
            end else if (wr_sec) begin
                divider_value_reg <= `RST_BYTE;
            end else if (step) begin
                divider_value_reg <= divider_value_reg + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // control, priority and enable registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_stop_reg <= 1'b0;
            tick_irq_level_reg <= `RST_LVL;
            en_reg <= `RST_EV;
        end else if (ce) begin
            if (wr_ctrl) begin
                run_stop_reg <= wdata[`B_RUN];
            end
            if (wr_prio) begin
                tick_irq_level_reg <= wdata[`B_PRIO_HI:`B_PRIO_LO];
            end
            if (wr_enab) begin
                en_reg <= wdata[`B_EV_HI:`B_EV_LO];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // tap-fall events; a clear to zero also counts as a fall of a high tap
    wire [7:0] div_fall = div_prev_reg & ~divider_value_reg;
    wire [`N_EV-1:0] ev_set = {sec_wrap && div_carry, div_fall[`TAP_1], div_fall[`TAP_2],
        div_fall[`TAP_8], div_fall[`TAP_32]};
    // set wins over the write-one clear
    always @* begin
        flag_next = flag_reg;
        if (wr_flag) begin
            flag_next = flag_reg & ~wdata[`B_EV_HI:`B_EV_LO];
        end
        flag_next = flag_next | ev_set;
    end
    // flag and previous-divider registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= `RST_EV;
            div_prev_reg <= `RST_BYTE;
        end else if (ce) begin
            flag_reg <= flag_next;
            div_prev_reg <= divider_value_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // interrupt request toward the cpu
    assign irq_req = |(flag_reg & en_reg) && tick_irq_level_reg != `RST_LVL;
    assign irq_level = irq_req ? tick_irq_level_reg : `RST_LVL;
    ////////////////////////////////////////////////////////////////////////
    // read mux, data one cycle after the strobe
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= `RST_BYTE;
        end else if (ce) begin
            if (!rd) begin
                rdata <= `RST_BYTE;
            end else if (addr == `A_PRIO) begin
                rdata <= {4'h0, tick_irq_level_reg, 2'h0};
            end else if (addr == `A_ENAB) begin
                rdata <= {en_reg, 3'h0};
            end else if (addr == `A_FLAG) begin
                rdata <= {flag_reg, 3'h0};
            end else if (addr == `A_CTRL) begin
                rdata <= {7'h00, run_stop_reg};
            end else if (addr == `A_DIV) begin
                rdata <= divider_value_reg;
            end else if (addr == `A_SEC) begin
                rdata <= {1'b0, seconds_value};
            end else begin
                rdata <= `RST_BYTE;
            end
        end
    end
endmodule

// file: test/cpu_bus_model.sv
// cpu side bus master model: one-cycle strobes, read data one cycle later
// assumes the timer's register port on the same clock
`timescale 1ns/1ps
module cpu_bus_model (
    input wire ref_clk,
    input wire [7:0] rdata,
    output reg [23:0] addr = 24'h000000,
    output reg [7:0] wdata = 8'h00,
    output reg wr = 1'b0,
    output reg rd = 1'b0
);
    ////////////////////////////////////////////////////////////////
    // one write cycle, strobe dropped after the edge that takes it
    task bus_wr(input [23:0] a, input [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // one read cycle, data taken once the taking edge has landed
    task bus_rd(input [23:0] a, output [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

// file: test/seconds_clock_timer_properties.sv
// checker for the seconds clock timer register reads and interrupt outputs
// assumes only the top module's ports, bound at the foot
`timescale 1ns/1ps
`include "tick_timer_defs.vh"
module seconds_clock_timer_checker (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire [23:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire [1:0] irq_level,
    input wire irq_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a read that the timer takes
    wire rd_ok = rd && ce;
    // address is one of the six registers
    wire mapped = addr == `A_PRIO || addr == `A_ENAB || addr == `A_FLAG
        || addr == `A_CTRL || addr == `A_DIV || addr == `A_SEC;
    ////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(rd) && $past(ce) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_level_off: assert property (!irq_req |-> irq_level == 2'h0)
        else $error("level shown without a request");
    a_req_level: assert property (irq_req |-> irq_level != 2'h0)
        else $error("request at level zero");
    a_ctrl_read: assert property (rd_ok && addr == `A_CTRL |=> rdata[7:1] == 7'h00)
        else $error("control clear or unused bits read high");
    a_sec_bcd: assert property (rd_ok && addr == `A_SEC |=> !rdata[7]
        && rdata[3:0] <= `UNITS_MAX && rdata[6:4] <= `TENS_MAX)
        else $error("seconds not valid bcd");
    a_event_low: assert property (rd_ok && (addr == `A_ENAB || addr == `A_FLAG)
        |=> rdata[2:0] == 3'h0)
        else $error("low enable or flag bits read high");
    a_prio_bits: assert property (rd_ok && addr == `A_PRIO
        |=> rdata[7:4] == 4'h0 && rdata[1:0] == 2'h0)
        else $error("foreign priority bits read high");
    a_unmapped: assert property (rd_ok && !mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    c_irq: cover property (irq_req);
    c_clear: cover property (wr && addr == `A_CTRL && wdata[1]);
    c_wrap: cover property (rd_ok && addr == `A_SEC ##1 rdata == 8'h00);
endmodule
bind seconds_clock_timer seconds_clock_timer_checker seconds_clock_timer_checker_i (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq_level(irq_level), .irq_req(irq_req));

// file: test/seconds_clock_timer_bench.sv
// self-checking bench for the seconds clock timer
// assumes a shortened tick of 4 clocks, so one second is 1024 clocks
`timescale 1ns/1ps
`include "tick_timer_defs.vh"
module seconds_clock_timer_bench;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg ce = 1'b1;
    wire [23:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire wr;
    wire rd;
    wire [1:0] irq_level;
    wire irq_req;
    integer error_cnt = 0;
    integer num_checks = 0;
    integer i;
    reg [31:0] lfsr = 32'h61F33034;
    reg [7:0] d;
    reg [7:0] v;
    reg [2:0] ie;
    seconds_clock_timer #(.TICK_CYCLES(4)) seconds_clock_timer_i (.ref_clk(ref_clk),
        .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq_level(irq_level), .irq_req(irq_req));
    cpu_bus_model cpu_bus_model_i (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    // 50 mhz clock
    initial forever #10 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected request and level from flags, enables and priority
    function [2:0] irq_exp(input [7:0] fl, input [7:0] e, input [1:0] p);
        irq_exp = (|(fl & e & 8'hF8) && p != 2'h0) ? {1'b1, p} : 3'h0;
    endfunction
    task check(input [7:0] seen, input [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task rd_chk(input [23:0] a, input [7:0] exp);
        cpu_bus_model_i.bus_rd(a, d);
        check(d, exp);
    endtask
    task final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(`A_DIV, 8'h00);
        rd_chk(`A_SEC, 8'h00);
        rd_chk(`A_ENAB, 8'h00);
        rd_chk(`A_FLAG, 8'h00);
        rd_chk(`A_PRIO, 8'h00);
        rd_chk(`A_CTRL, 8'h00);
        rd_chk(24'h00FF53, 8'h00);
        // random valid presets while stopped, divider writes ignored
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            v = {1'b0, lfsr[6:4] % 3'h6, lfsr[3:0] % 4'hA};
            cpu_bus_model_i.bus_wr(`A_SEC, v);
            cpu_bus_model_i.bus_wr(`A_DIV, lfsr[15:8]);
            rd_chk(`A_SEC, v);
            rd_chk(`A_DIV, 8'h00);
        end
        // preset 59 and run one second: wrap to zero, every event flagged
        cpu_bus_model_i.bus_wr(`A_SEC, 8'h59);
        cpu_bus_model_i.bus_wr(`A_CTRL, 8'h01);
        repeat (1100) @(posedge ref_clk);
        cpu_bus_model_i.bus_wr(`A_CTRL, 8'h00);
        rd_chk(`A_SEC, 8'h00);
        rd_chk(`A_FLAG, 8'hF8);
        cpu_bus_model_i.bus_wr(`A_FLAG, 8'h88);
        rd_chk(`A_FLAG, 8'h70);
        // random enables and priority against the remaining flags
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = lfsr_next(lfsr);
            cpu_bus_model_i.bus_wr(`A_ENAB, lfsr[7:0]);
            cpu_bus_model_i.bus_wr(`A_PRIO, lfsr[15:8]);
            ie = irq_exp(8'h70, lfsr[7:0], lfsr[11:10]);
            #1 check({5'h00, irq_req, irq_level}, {5'h00, ie});
            rd_chk(`A_ENAB, lfsr[7:0] & 8'hF8);
        end
        cpu_bus_model_i.bus_wr(`A_FLAG, 8'hFF);
        #1 check({7'h00, irq_req}, 8'h00);
        // one and a half seconds from a preset, then clear while running
        cpu_bus_model_i.bus_wr(`A_SEC, 8'h37);
        cpu_bus_model_i.bus_wr(`A_CTRL, 8'h01);
        repeat (1536) @(posedge ref_clk);
        rd_chk(`A_SEC, 8'h38);
        cpu_bus_model_i.bus_wr(`A_CTRL, 8'h03);
        repeat (1536) @(posedge ref_clk);
        rd_chk(`A_SEC, 8'h01);
        // stop and clear together: zeros must hold
        cpu_bus_model_i.bus_wr(`A_CTRL, 8'h02);
        repeat (300) @(posedge ref_clk);
        rd_chk(`A_DIV, 8'h00);
        rd_chk(`A_SEC, 8'h00);
        final_report;
    end
    // watchdog, well past the expected run of some 5000 clocks
    initial begin
        #(20 * 20000);
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule
